// ---- rtl/sfd_cfg.svh ----
// command codes, field positions and register defaults for the spi frame decoder
`ifndef SFD_CFG_SVH
`define SFD_CFG_SVH
`define SFD_FRAME_W      16
`define SFD_CMD_HI       15
`define SFD_CMD_LO       14
`define SFD_ADDR_HI      10
`define SFD_ADDR_LO      8
`define SFD_DATA_HI      7
`define SFD_DATA_LO      0
`define SFD_CMD_DIAG     2'h0
`define SFD_CMD_READ     2'h1
`define SFD_CMD_RESET    2'h2
`define SFD_CMD_WRITE    2'h3
`define SFD_ADDR_MAP     3'h1
`define SFD_ADDR_BOL     3'h2
`define SFD_ADDR_OVL     3'h3
`define SFD_ADDR_OVT     3'h4
`define SFD_ADDR_SLE     3'h5
`define SFD_ADDR_STAT    3'h6
`define SFD_ADDR_CTL     3'h7
`define SFD_DEF_MAP      8'h08
`define SFD_DEF_OTHER    8'h00
`define SFD_RDHDR        5'h08
`endif

// ---- rtl/sfd_pkg.sv ----
// types shared by the spi frame decoder
package sfd_pkg;
    typedef struct packed {
        logic [7:0] map;
        logic [7:0] bol;
        logic [7:0] ovl;
        logic [7:0] ovt;
        logic [7:0] sle;
        logic [7:0] ctl;
    } sfd_regs_t;
endpackage

// ---- rtl/sfd_decoder.sv ----
// spi slave frame decoder with control register bank
// Operation
// - bits 15:14 hold command; 00 only returns diagnosis, registers untouched
// - command 01 captures addressed register, sent during next frame
// - command 10 returns every register to its default, ignoring address and data
// - command 11 stores data byte into addressed register
// - bits 10:8 select the register for read and write
// - bits 7:0 carry write data and returned read data
// - reset loads all registers with defaults before any frame
// - decode on chip select rise only if clock count is nonzero multiple of 8
// - msb first, sample input on falling clock, update output on rising clock
// - chip select fall loads diagnosis; rise clears latched diagnosis flags
// - read takes two frames; second frame may carry a new command
`include "sfd_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sfd_decoder
    import sfd_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    input  wire logic        CS_N,
    input  wire logic        SCLK,
    input  wire logic        SI,
    input  wire logic [15:0] DIAG_IN,
    input  wire logic [7:0]  STATUS_IN,
    output logic             SO_O,
    output logic             SO_OE,
    output sfd_regs_t        REGS,
    output logic             DIAG_CLR
);
    typedef struct packed {
        // pin synchronisers and delayed copies for edge finding
        logic [1:0]  cs_s;
        logic [1:0]  sck_s;
        logic [1:0]  si_s;
        logic        cs_d;
        logic        sck_d;
        // frame shift path
        logic [15:0] sh;
        logic [15:0] tx;
        logic [5:0]  cnt;
        // answer held for the frame after a read command
        logic        rd_pend;
        logic [15:0] rd_word;
        // register bank and pin drivers
        sfd_regs_t   regs;
        logic        so;
        logic        oe;
        logic        dclr;
    } sfd_state_t;

    sfd_state_t st_ff;
    sfd_state_t nxt_st;

    // one source of power-on values, shared by reset and the reset command
    function automatic sfd_regs_t sfd_defaults();
        sfd_regs_t r;
        r     = '{default: `SFD_DEF_OTHER};
        r.map = `SFD_DEF_MAP;
        return r;
    endfunction

    // status comes straight from its input; the unused address zero reads as zero
    function automatic logic [7:0] sfd_rd(
        input sfd_regs_t  r,
        input logic [2:0] a,
        input logic [7:0] stat
    );
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            `SFD_ADDR_MAP:  v = r.map;
            `SFD_ADDR_BOL:  v = r.bol;
            `SFD_ADDR_OVL:  v = r.ovl;
            `SFD_ADDR_OVT:  v = r.ovt;
            `SFD_ADDR_SLE:  v = r.sle;
            `SFD_ADDR_STAT: v = stat;
            `SFD_ADDR_CTL:  v = r.ctl;
            default:        v = 8'h00;
        endcase
        return v;
    endfunction

    // writes to the read-only status address or to address zero are dropped
    function automatic sfd_regs_t sfd_wr(
        input sfd_regs_t  r,
        input logic [2:0] a,
        input logic [7:0] d
    );
        sfd_regs_t w;
        w = r;
        unique case (a)
            `SFD_ADDR_MAP: w.map = d;
            `SFD_ADDR_BOL: w.bol = d;
            `SFD_ADDR_OVL: w.ovl = d;
            `SFD_ADDR_OVT: w.ovt = d;
            `SFD_ADDR_SLE: w.sle = d;
            `SFD_ADDR_CTL: w.ctl = d;
            default: ;
        endcase
        return w;
    endfunction

    logic        cs_fall;
    logic        cs_rise;
    logic        sck_fall;
    logic        sck_rise;
    logic [1:0]  cmd;
    logic [2:0]  addr;
    logic [7:0]  dat;
    logic        frame_ok;
    logic [15:0] load_word;
    logic [15:0] rd_answer;

    // edges compare the second synchroniser stage with its delayed copy;
    // clock edges seen while chip select is high are ignored
    always_comb begin
        cs_fall  = st_ff.cs_d & ~st_ff.cs_s[1];
        cs_rise  = ~st_ff.cs_d & st_ff.cs_s[1];
        sck_fall = st_ff.sck_d & ~st_ff.sck_s[1] & ~st_ff.cs_s[1];
        sck_rise = ~st_ff.sck_d & st_ff.sck_s[1] & ~st_ff.cs_s[1];
    end

    always_comb begin
        // bits 13:11 are not looked at
        cmd  = st_ff.sh[`SFD_CMD_HI:`SFD_CMD_LO];
        addr = st_ff.sh[`SFD_ADDR_HI:`SFD_ADDR_LO];
        dat  = st_ff.sh[`SFD_DATA_HI:`SFD_DATA_LO];
    end

    // refuse empty, partial-byte and saturated frames; flags are still cleared
    always_comb begin
        frame_ok = (st_ff.cnt != 6'h00) && (st_ff.cnt[2:0] == 3'h0) && (st_ff.cnt != 6'h3f);
    end

    // a pending read answer replaces the diagnosis word for one frame only
    always_comb begin
        if (st_ff.rd_pend) begin
            load_word = st_ff.rd_word;
        end else begin
            load_word = DIAG_IN;
        end
    end

    // the answer is frozen at the end of the read frame, so a write in the next
    // frame cannot change what the master gets back
    always_comb begin
        rd_answer = {`SFD_RDHDR, addr, sfd_rd(st_ff.regs, addr, STATUS_IN)};
    end

    always_comb begin
        nxt_st       = st_ff;
        nxt_st.cs_s  = {st_ff.cs_s[0], CS_N};
        nxt_st.sck_s = {st_ff.sck_s[0], SCLK};
        nxt_st.si_s  = {st_ff.si_s[0], SI};
        nxt_st.cs_d  = st_ff.cs_s[1];
        nxt_st.sck_d = st_ff.sck_s[1];
        nxt_st.dclr  = 1'b0;

        if (cs_fall) begin
            nxt_st.cnt     = 6'h00;
            nxt_st.oe      = 1'b1;
            nxt_st.tx      = load_word;
            nxt_st.so      = load_word[15];
            nxt_st.rd_pend = 1'b0;
        end

        // the first rising edge keeps bit 15, already placed at chip select fall
        if (sck_rise && st_ff.cnt != 6'h00) begin
            nxt_st.so = st_ff.tx[15];
        end

        if (sck_fall) begin
            // input capture and output shift share the falling edge; output shows it on next rise
            nxt_st.sh  = {st_ff.sh[14:0], st_ff.si_s[1]};
            nxt_st.tx  = {st_ff.tx[14:0], st_ff.sh[15]};
            // saturating count keeps long daisy-chain frames from wrapping to a false multiple
            if (st_ff.cnt != 6'h3f) begin
                nxt_st.cnt = st_ff.cnt + 6'h01;
            end
        end

        // output enable drops with chip select so the pin floats between frames
        if (cs_rise) begin
            nxt_st.oe   = 1'b0;
            nxt_st.dclr = 1'b1;
            if (frame_ok) begin
                unique case (cmd)
                    `SFD_CMD_DIAG: ;
                    `SFD_CMD_READ: begin
                        nxt_st.rd_pend = 1'b1;
                        nxt_st.rd_word = rd_answer;
                    end
                    `SFD_CMD_RESET: nxt_st.regs = sfd_defaults();
                    `SFD_CMD_WRITE: nxt_st.regs = sfd_wr(st_ff.regs, addr, dat);
                endcase
            end
        end
    end

    // chip select synchroniser starts idle-high so leaving reset never looks like a frame start
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            st_ff         <= '0;
            st_ff.cs_s    <= 2'h3;
            st_ff.cs_d    <= 1'b1;
            st_ff.regs    <= sfd_defaults();
        end else begin
            st_ff <= nxt_st;
        end
    end

    // every output is a register bit; nothing combinational reaches a pin
    assign SO_O     = st_ff.so;
    assign SO_OE    = st_ff.oe;
    assign REGS     = st_ff.regs;
    assign DIAG_CLR = st_ff.dclr;
endmodule
`default_nettype wire

// ---- tb/sfd_decoder_checker.sv ----
// port assertions for the spi frame decoder
`timescale 1ns/1ps
`default_nettype none
`include "sfd_cfg.svh"
module sfd_chk
    import sfd_pkg::*;
(
    input wire logic        CLK,
    input wire logic        SYS_RST,
    input wire logic        CS_N,
    input wire logic        SCLK,
    input wire logic        SI,
    input wire logic        SO_O,
    input wire logic        SO_OE,
    input wire logic        DIAG_CLR,
    input wire logic [15:0] DIAG_IN,
    input wire sfd_regs_t   REGS
);
    logic [15:0] si_shift;
    logic [5:0]  si_cnt;
    logic        rd_seen;

    // shadow of the frame the master sent, to know whether a read answer is due
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            si_shift <= 16'h0000;
            si_cnt   <= 6'h00;
            rd_seen  <= 1'b0;
        end else begin
            if ($fell(SCLK) && !CS_N) begin
                si_shift <= {si_shift[14:0], SI};
                if (si_cnt != 6'h3f) begin
                    si_cnt <= si_cnt + 6'h01;
                end
            end
            if ($fell(CS_N)) begin
                si_cnt <= 6'h00;
            end
            if ($rose(CS_N)) begin
                rd_seen <= (si_cnt != 6'h00) && (si_cnt[2:0] == 3'h0) && (si_shift[15:14] == `SFD_CMD_READ);
            end
        end
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    sequence s_low;
        (SO_OE && !CS_N && !SCLK)[*6];
    endsequence
    AST_OE_OFF: assert property (CS_N[*8] |-> !SO_OE) else $error("so driven idle");
    AST_OE_ON: assert property (!CS_N[*8] |-> SO_OE) else $error("so not driven");
    AST_CLR: assert property ($rose(CS_N) |-> ##[2:5] DIAG_CLR) else $error("no clear");
    AST_PULSE: assert property (DIAG_CLR |=> !DIAG_CLR) else $error("long clear");
    AST_NOCLR: assert property (CS_N[*8] |-> !DIAG_CLR) else $error("stray clear");
    AST_REGS: assert property (!CS_N |=> $stable(REGS)) else $error("regs moved");
    AST_FIRST: assert property ($rose(SO_OE) |-> SO_O == (rd_seen ? 1'b0 : DIAG_IN[15])) else $error("bad msb");
    // so may only move after a clock rise, so a long low phase freezes it
    AST_SO: assert property (s_low |=> $stable(SO_O)) else $error("so moved");
endmodule
bind sfd_decoder sfd_chk i_sfd_chk (
    .CLK      (CLK),
    .SYS_RST  (SYS_RST),
    .CS_N     (CS_N),
    .SCLK     (SCLK),
    .SI       (SI),
    .SO_O     (SO_O),
    .SO_OE    (SO_OE),
    .DIAG_CLR (DIAG_CLR),
    .DIAG_IN  (DIAG_IN),
    .REGS     (REGS)
);
`default_nettype wire

// ---- tb/sfd_host.sv ----
// spi master model framing commands for the decoder
`timescale 1ns/1ps
`default_nettype none
module sfd_host (
    output logic     CS_N,
    output logic     SCLK,
    output logic     SI,
    input wire logic SO_O
);
    int pad = 0;
    initial {CS_N, SCLK, SI} = 3'b100;
    // si falls to its pull-down level outside frames
    task automatic xfer(input logic [15:0] w, output logic [15:0] r);
        logic [31:0] v;
        v = {16'h0000, w};
        CS_N = 1'b0;
        #300;
        for (int i = pad + 15; i >= 0; i--) begin
            {SCLK, SI} = {1'b1, v[i]};
            // the device moves so on the rising edge, so read it late in the high phase
            #62.5 r = {r[14:0], SO_O};
            SCLK = 1'b0;
            #62.5;
        end
        #250 {CS_N, SI} = 2'b10;
        #300;
    endtask
endmodule
`default_nettype wire

// ---- tb/sfd_decoder_bench.sv ----
// self-checking bench for the spi frame decoder
`timescale 1ns/1ps
`default_nettype none
module sfd_decoder_bench;
    logic CLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic CS_N, SCLK, SI, SO_O, SO_OE, DIAG_CLR;
    logic [15:0] DIAG_IN = 16'ha5c3;
    logic [7:0] STATUS_IN = 8'h3c;
    sfd_pkg::sfd_regs_t REGS;
    logic [7:0] e [8];
    logic [15:0] r;
    int err_count = 0;
    int total_checks = 0;
    always #5 CLK = ~CLK;
    sfd_decoder i_sfd_decoder (
        .CLK       (CLK),
        .SYS_RST   (SYS_RST),
        .CS_N      (CS_N),
        .SCLK      (SCLK),
        .SI        (SI),
        .DIAG_IN   (DIAG_IN),
        .STATUS_IN (STATUS_IN),
        .SO_O      (SO_O),
        .SO_OE     (SO_OE),
        .REGS      (REGS),
        .DIAG_CLR  (DIAG_CLR)
    );
    sfd_host i_sfd_host (
        .CS_N (CS_N),
        .SCLK (SCLK),
        .SI   (SI),
        .SO_O (SO_O)
    );
    task automatic chk(input logic [47:0] s, input logic [47:0] x);
        total_checks++;
        if (s !== x) begin
            err_count++;
            $display("Error %0t: %h vs %h", $time, s, x);
        end
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    function automatic logic [47:0] ev();
        return {e[1], e[2], e[3], e[4], e[5], e[7]};
    endfunction
    task automatic cmd(input logic [1:0] c, input logic [2:0] a, input logic [7:0] d);
        i_sfd_host.xfer({c, 3'h0, a, d}, r);
    endtask
    initial begin
        e = '{default: 8'h00};
        e[1] = 8'h08;
        e[6] = STATUS_IN;
        repeat (8) @(posedge CLK);
        #1 SYS_RST = 1'b0;
        repeat (3) @(posedge CLK);
        chk(REGS, ev());
        cmd(2'h0, 3'h1, 8'hff);
        chk(r, DIAG_IN);
        chk(REGS, ev());
        for (int a = 1; a < 8; a++) begin
            cmd(2'h3, a[2:0], 8'h11 * a[7:0]);
            if (a != 6) e[a] = 8'h11 * a[7:0];
        end
        chk(REGS, ev());
        // back-to-back reads: each frame after the first returns the previous request
        for (int a = 0; a < 9; a++) begin
            cmd(a < 8 ? 2'h1 : 2'h0, a[2:0], 8'h00);
            if (a > 0) chk(r, {5'h08, 3'(a - 1), e[a - 1]});
        end
        i_sfd_host.pad = 7;
        cmd(2'h3, 3'h2, 8'h5a);
        chk(REGS, ev());
        i_sfd_host.pad = 8;
        cmd(2'h3, 3'h2, 8'h5a);
        e[2] = 8'h5a;
        chk(REGS, ev());
        i_sfd_host.pad = 0;
        cmd(2'h2, 3'h3, 8'hff);
        chk(REGS, 48'h080000000000);
        summarize();
    end
    initial begin
        #500000;
        err_count++;
        summarize();
    end
endmodule
`default_nettype wire
